// ---- design/vic_pkg.sv ----
// Purpose: Shared constants for the vectored interrupt controller
// Assumes: One system clock, active-low asynchronous reset
// Notes:   Channel numbers place each peripheral request on a fixed input bit
package irq_ctrl_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CHANNELS  = 32;
    localparam int NUM_SLOTS     = 16;
    localparam int SLOT_IDX_W    = 5;
    localparam int ADDR_W        = 32;

    // ------------------------------------------------------------------
    // Channel positions of the on-chip sources
    // ------------------------------------------------------------------
    localparam int CH_WATCHDOG   = 0;
    localparam int CH_SOFT_ONLY  = 1;
    localparam int CH_DBG_RX     = 2;
    localparam int CH_DBG_TX     = 3;
    localparam int CH_TIMER0     = 4;
    localparam int CH_TIMER1     = 5;
    localparam int CH_SERIAL0    = 6;
    localparam int CH_SERIAL1    = 7;
    localparam int CH_PWM        = 8;
    localparam int CH_TWO_WIRE   = 9;
    localparam int CH_SYNC0      = 10;
    localparam int CH_SYNC1      = 11;
    localparam int CH_SYNTH      = 12;
    localparam int CH_CLOCK      = 13;
    localparam int CH_EXT0       = 14;
    localparam int CH_ADC        = 18;
    localparam int NUM_EXT       = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [NUM_CHANNELS-1:0] RST_MASK = 32'h0000_0000;
    localparam logic [ADDR_W-1:0]       RST_ADDR = 32'h0000_0000;

endpackage : irq_ctrl_pkg

// ---- design/vectored_irq_ctrl.sv ----
// Purpose: Sort peripheral requests into fast, vectored and default classes
//          and drive the core's fast_irq and normal irq inputs
// Assumes: Peripheral flags are on this clock; ext_irq and the software
//          request bit come from outside and are synchronised here
// Notes:   Configuration arrives as plain ports, used live with no register of its own
`timescale 1ns/10ps
module vectored_irq_ctrl
    import irq_ctrl_pkg::*;
(
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_rst_n,
    // Peripheral flags
    input  wire logic                         i_watchdog_event,
    input  wire logic                         i_soft_request,
    input  wire logic                         i_debug_comm_receive,
    input  wire logic                         i_debug_comm_transmit,
    input  wire logic [3:0]                   i_t0_match_flags,
    input  wire logic [3:0]                   i_t0_capture_flags,
    input  wire logic [3:0]                   i_t1_match_flags,
    input  wire logic [3:0]                   i_t1_capture_flags,
    input  wire logic [3:0]                   i_serial0_flags,
    input  wire logic [4:0]                   i_serial1_flags,
    input  wire logic [6:0]                   i_pwm_match_flags,
    input  wire logic                         i_two_wire_state_flag,
    input  wire logic [1:0]                   i_sync0_flags,
    input  wire logic [1:0]                   i_sync1_flags,
    input  wire logic [3:0]                   i_buffered_flags,
    input  wire logic                         i_synth_lock_event,
    input  wire logic                         i_clock_increment_event,
    input  wire logic                         i_clock_alarm_event,
    input  wire logic [NUM_EXT-1:0]           i_ext_irq,
    input  wire logic                         i_adc_event,
    // Configuration
    input  wire logic [NUM_CHANNELS-1:0]      i_enable,
    input  wire logic [NUM_CHANNELS-1:0]      i_fast_select,
    input  wire logic [NUM_SLOTS-1:0]         i_slot_enable,
    input  wire logic [NUM_SLOTS*SLOT_IDX_W-1:0] i_slot_channel,
    input  wire logic [NUM_SLOTS*ADDR_W-1:0]  i_slot_addr,
    input  wire logic [ADDR_W-1:0]            i_default_addr,
    // Core side and status
    output logic                              o_fast_irq,
    output logic                              o_irq,
    output logic [NUM_CHANNELS-1:0]           o_fast_status,
    output logic [NUM_CHANNELS-1:0]           o_normal_status,
    output logic [NUM_CHANNELS-1:0]           o_raw_status,
    output logic [ADDR_W-1:0]                 o_vector_addr
);

    // ------------------------------------------------------------------
    // Pin synchroniser for the software and external lines
    // ------------------------------------------------------------------
    // Bit 0 carries the software request, bits 1 up the external lines
    localparam int NUM_ASYNC = NUM_EXT + 1;
    logic [NUM_ASYNC-1:0] sync1_r;
    logic [NUM_ASYNC-1:0] sync2_r;
    logic [NUM_ASYNC-1:0] sync3_r;
    logic [NUM_ASYNC-1:0] async_level_r;

    // Third stage filters a level that is still settling
    // A one-cycle glitch on a pin never reaches a channel, at the cost of
    // four cycles of extra latency on these lines
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_r       <= '0;
            sync2_r       <= '0;
            sync3_r       <= '0;
            async_level_r <= '0;
        end else begin
            sync1_r       <= {i_ext_irq, i_soft_request};
            sync2_r       <= sync1_r;
            sync3_r       <= sync2_r;
            async_level_r <= (sync2_r & sync3_r) | (async_level_r & (sync2_r | sync3_r));
        end
    end

    // ------------------------------------------------------------------
    // Request line per channel
    // ------------------------------------------------------------------
    logic [NUM_CHANNELS-1:0] raw_req;

    // Each peripheral's flags are ORed onto one line
    // Channels above the converter have no source and stay low
    always_comb begin
        raw_req                       = '0;
        raw_req[CH_WATCHDOG]          = i_watchdog_event;
        raw_req[CH_SOFT_ONLY]         = async_level_r[0];
        raw_req[CH_DBG_RX]            = i_debug_comm_receive;
        raw_req[CH_DBG_TX]            = i_debug_comm_transmit;
        raw_req[CH_TIMER0]            = |{i_t0_match_flags, i_t0_capture_flags};
        raw_req[CH_TIMER1]            = |{i_t1_match_flags, i_t1_capture_flags};
        raw_req[CH_SERIAL0]           = |i_serial0_flags;
        raw_req[CH_SERIAL1]           = |i_serial1_flags;
        raw_req[CH_PWM]               = |i_pwm_match_flags;
        raw_req[CH_TWO_WIRE]          = i_two_wire_state_flag;
        raw_req[CH_SYNC0]             = |i_sync0_flags;
        raw_req[CH_SYNC1]             = |{i_sync1_flags, i_buffered_flags};
        raw_req[CH_SYNTH]             = i_synth_lock_event;
        raw_req[CH_CLOCK]             = i_clock_increment_event | i_clock_alarm_event;
        raw_req[CH_EXT0 +: NUM_EXT]   = async_level_r[NUM_ASYNC-1:1];
        raw_req[CH_ADC]               = i_adc_event;
    end

    // ------------------------------------------------------------------
    // Classification, driven live from the configuration ports
    // ------------------------------------------------------------------
    // A channel with its fast bit set leaves the normal class entirely
    wire logic [NUM_CHANNELS-1:0] active_req = raw_req & i_enable;
    wire logic [NUM_CHANNELS-1:0] fast_req   = active_req & i_fast_select;
    wire logic [NUM_CHANNELS-1:0] normal_req = active_req & ~i_fast_select;

    // Channel picked by one slot
    function automatic logic [SLOT_IDX_W-1:0] slot_chan(input int s,
            input logic [NUM_SLOTS*SLOT_IDX_W-1:0] tbl);
        slot_chan = tbl[s*SLOT_IDX_W +: SLOT_IDX_W];
    endfunction : slot_chan

    logic [NUM_SLOTS-1:0]    slot_hit;
    logic [NUM_CHANNELS-1:0] vectored_chan;

    // A slot fires when its channel requests in the normal class
    // A fast channel never fires a slot, so the vector comes from the lowest slot still hit
    // Several slots may name one channel; the lowest of them decides
    always_comb begin
        vectored_chan = '0;
        for (int s = 0; s < NUM_SLOTS; s++) begin
            slot_hit[s] = i_slot_enable[s] && normal_req[slot_chan(s, i_slot_channel)];
            if (i_slot_enable[s]) begin
                vectored_chan[slot_chan(s, i_slot_channel)] = 1'b1;
            end
        end
    end

    // Unassigned enabled normal requests fall to the default class
    wire logic [NUM_CHANNELS-1:0] default_req = normal_req & ~vectored_chan;

    logic [ADDR_W-1:0] vec_nxt;

    // Lowest slot number wins; default address only when no slot fires
    // The loop walks down from slot 15 so that a lower hit overwrites it
    always_comb begin
        vec_nxt = i_default_addr;
        for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
            if (slot_hit[s]) begin
                vec_nxt = i_slot_addr[s*ADDR_W +: ADDR_W];
            end
        end
    end

    // ------------------------------------------------------------------
    // Output registers: one cycle behind the requests, never held
    // ------------------------------------------------------------------
    // Registering costs a cycle but keeps decode glitches off the core's lines
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fast_irq      <= 1'b0;
            o_irq           <= 1'b0;
            o_fast_status   <= RST_MASK;
            o_normal_status <= RST_MASK;
            o_raw_status    <= RST_MASK;
            o_vector_addr   <= RST_ADDR;
        end else begin
            o_fast_irq      <= |fast_req;
            o_irq           <= |(slot_hit) | (|default_req);
            o_fast_status   <= fast_req;
            o_normal_status <= normal_req;
            o_raw_status    <= raw_req;
            o_vector_addr   <= vec_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Merge checks skip the first edge after reset, whose past value
    // still comes from inside reset while the outputs were held low
    a_fast_merge: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> o_fast_irq == |$past(fast_req))
        else $error("fast_irq does not follow fast requests");

    a_fast_status: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> o_fast_status == ($past(raw_req) & $past(i_enable) & $past(i_fast_select)))
        else $error("fast status mismatch");

    a_irq_merge: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> o_irq == (|$past(slot_hit) || |$past(default_req)))
        else $error("irq does not follow normal requests");

    a_slot0_wins: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        slot_hit[0] |=> o_vector_addr == $past(i_slot_addr[ADDR_W-1:0]))
        else $error("slot 0 not served first");

    a_default_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !(|slot_hit) |=> o_vector_addr == $past(i_default_addr))
        else $error("default address not given");

    a_fast_not_irq: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (active_req == i_fast_select && |active_req) |=> o_fast_irq && !o_irq)
        else $error("fast request leaked onto irq");

    a_normal_status: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ((o_normal_status & o_fast_status) == '0))
        else $error("channel in both classes");

    a_level_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (raw_req == '0) |=> !o_fast_irq && !o_irq)
        else $error("output held without request");

    a_watchdog_ch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_watchdog_event |=> o_raw_status[CH_WATCHDOG])
        else $error("watchdog channel wrong");

    a_ext_sync: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_ext_irq[0] [*5]) |=> o_raw_status[CH_EXT0])
        else $error("external line not seen");

    // ------------------------------------------------------------------
    // Priority, status words, synchroniser and channel map
    // ------------------------------------------------------------------
    // Each peripheral check looks one edge later, at the registered raw word
    a_slot1_next: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (slot_hit[1] && !slot_hit[0]) |=> o_vector_addr == $past(i_slot_addr[ADDR_W +: ADDR_W]))
        else $error("slot 1 not served after slot 0");

    a_slot15_last: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (slot_hit == 16'h8000) |=> o_vector_addr == $past(i_slot_addr[15*ADDR_W +: ADDR_W]))
        else $error("slot 15 not served alone");

    a_idle_channels: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_raw_status[NUM_CHANNELS-1:CH_ADC+1] == '0)
        else $error("channel without source is active");

    a_normal_masked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ((o_normal_status | o_fast_status) & ~o_raw_status) == '0)
        else $error("status bit without raw request");

    a_soft_sync: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_soft_request [*5]) |=> o_raw_status[CH_SOFT_ONLY])
        else $error("software request not seen");

    a_sync_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (sync2_r[0] != sync3_r[0]) |=> async_level_r[0] == $past(async_level_r[0]))
        else $error("software level moved while stages disagree");

    a_dbg_rx_ch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_debug_comm_receive |=> o_raw_status[CH_DBG_RX])
        else $error("debug receive channel wrong");

    a_timer_merge: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (|{i_t0_match_flags, i_t0_capture_flags}) |=> o_raw_status[CH_TIMER0])
        else $error("timer flags not merged");

    a_serial1_merge: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (|i_serial1_flags) |=> o_raw_status[CH_SERIAL1])
        else $error("second serial flags not merged");

    a_pwm_merge: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (|i_pwm_match_flags) |=> o_raw_status[CH_PWM])
        else $error("pwm match flags not merged");

    a_sync1_merge: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (|{i_sync1_flags, i_buffered_flags}) |=> o_raw_status[CH_SYNC1])
        else $error("shared serial channel not merged");

    a_clock_merge: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clock_increment_event || i_clock_alarm_event) |=> o_raw_status[CH_CLOCK])
        else $error("clock events not merged");

    a_adc_ch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_adc_event |=> o_raw_status[CH_ADC])
        else $error("converter channel wrong");

    // Main scenarios the bench is expected to reach
    c_fast: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_fast_irq);
    c_vectored: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_irq && |o_normal_status && o_vector_addr != i_default_addr);
    c_two_slots: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        slot_hit[0] && slot_hit[1]);
    c_fast_and_irq: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_fast_irq && o_irq);
    c_default_vec: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_irq && o_vector_addr == i_default_addr);

endmodule : vectored_irq_ctrl

// ---- bench/core_model.sv ----
// Purpose: Core side model that counts fast and normal entries
// Assumes: The core enters a handler on each rise of a request level
// Notes:   Watches only; it drives nothing back into the block
`timescale 1ns/10ps
module core_model (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_fast_irq,
    input  wire logic i_irq,
    output int        o_fast_cnt,
    output int        o_irq_cnt
);
    // ------------------------------------------------------------
    // Entry counting
    // ------------------------------------------------------------
    logic fast_r;
    logic irq_r;
    // A held level is one entry, so only rises are counted
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fast_r <= 1'b0;
            irq_r <= 1'b0;
            o_fast_cnt <= 0;
            o_irq_cnt <= 0;
        end else begin
            fast_r <= i_fast_irq;
            irq_r <= i_irq;
            if (i_fast_irq && !fast_r) o_fast_cnt <= o_fast_cnt + 1;
            if (i_irq && !irq_r) o_irq_cnt <= o_irq_cnt + 1;
        end
    end
endmodule : core_model

// ---- bench/vectored_irq_ctrl_tb.sv ----
// Purpose: Self-checking bench for the interrupt controller
// Assumes: One cycle latency, synchronised lines settle in five
// Notes:   Six cycles are left after every flag or configuration change to cover both
`timescale 1ns/10ps
module vectored_irq_ctrl_tb;
    import irq_ctrl_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        i_ref_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [52:0] fl = '0;
    logic [31:0] en = '0;
    logic [31:0] fs = '0;
    logic [15:0] sen = '0;
    logic [79:0] sch = '0;
    logic [511:0] sad = '0;
    logic [31:0] dad = 32'h0000_0ff0;
    logic        o_fast_irq, o_irq;
    logic [31:0] o_fast_status, o_normal_status, o_raw_status, o_vector_addr;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          fc, ic, i0;
    vectored_irq_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_watchdog_event(fl[0]), .i_soft_request(fl[1]),
        .i_debug_comm_receive(fl[2]), .i_debug_comm_transmit(fl[3]),
        .i_t0_match_flags(fl[7:4]), .i_t0_capture_flags(fl[11:8]),
        .i_t1_match_flags(fl[15:12]), .i_t1_capture_flags(fl[19:16]),
        .i_serial0_flags(fl[23:20]), .i_serial1_flags(fl[28:24]),
        .i_pwm_match_flags(fl[35:29]), .i_two_wire_state_flag(fl[36]),
        .i_sync0_flags(fl[38:37]), .i_sync1_flags(fl[40:39]),
        .i_buffered_flags(fl[44:41]), .i_synth_lock_event(fl[45]),
        .i_clock_increment_event(fl[46]), .i_clock_alarm_event(fl[47]),
        .i_ext_irq(fl[51:48]), .i_adc_event(fl[52]), .i_enable(en),
        .i_fast_select(fs), .i_slot_enable(sen), .i_slot_channel(sch),
        .i_slot_addr(sad), .i_default_addr(dad), .o_fast_irq(o_fast_irq),
        .o_irq(o_irq), .o_fast_status(o_fast_status),
        .o_normal_status(o_normal_status), .o_raw_status(o_raw_status),
        .o_vector_addr(o_vector_addr));
    core_model i_core (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_fast_irq(o_fast_irq), .i_irq(o_irq), .o_fast_cnt(fc),
        .o_irq_cnt(ic));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // Channel that each flag bit lands on
    function automatic int ch_of(input int b);
        if (b < 4) return b;
        if (b < 12) return 4;
        if (b < 20) return 5;
        if (b < 24) return 6;
        if (b < 29) return 7;
        if (b < 36) return 8;
        if (b == 36) return 9;
        if (b < 39) return 10;
        if (b < 45) return 11;
        if (b == 45) return 12;
        if (b < 48) return 13;
        if (b < 52) return 14 + b - 48;
        return 18;
    endfunction : ch_of
    // Drives change on falling edges only
    task automatic wt(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : wt
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic close_out();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // A hang is cut short here and counted
    initial begin
        #400000;
        n_mismatch++;
        close_out();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        for (int s = 0; s < 16; s++) begin
            sad[32*s +: 32] = 32'h0000_1000 + 32'(s * 4);
            sch[5*s +: 5] = 5'(s + 2);
        end
        wt(5);
        i_rst_n = 1'b1;
        wt(2);
        // Every flag alone, all enabled, nothing in a slot
        en = '1;
        i0 = ic;
        for (int b = 0; b < 53; b++) begin
            fl = 53'h1 << b;
            wt(6);
            chk("raw", o_raw_status, 32'h1 << ch_of(b));
            chk("normal", o_normal_status, 32'h1 << ch_of(b));
            chk("irq", o_irq, 32'h1);
            chk("vector", o_vector_addr, dad);
            fl = '0;
            wt(6);
            chk("irq off", o_irq, 32'h0);
        end
        chk("entries", ic - i0, 32'd53);
        $display("test sources done");
        // Slots dropped one by one at run time
        fl = '1;
        for (int s = 0; s < 16; s++) begin
            sen = 16'hffff << s;
            wt(6);
            chk("slot vector", o_vector_addr, 32'h0000_1000 + 32'(s * 4));
        end
        sen = '0;
        wt(6);
        chk("default vector", o_vector_addr, dad);
        $display("test slots done");
        // Fast class alone, then beside the normal ones
        fs = 32'h1;
        en = 32'h1;
        wt(6);
        chk("fast", o_fast_irq, 32'h1);
        chk("fast status", o_fast_status, 32'h1);
        chk("irq", o_irq, 32'h0);
        en = '1;
        wt(6);
        chk("normal", o_normal_status, 32'h0007_fffe);
        chk("fast status", o_fast_status, 32'h1);
        fl = '0;
        wt(6);
        chk("fast off", o_fast_irq, 32'h0);
        chk("fast entries", fc, 32'd1);
        $display("test fast done");
        // Disabled channels show raw only
        en = '0;
        fl = '1;
        wt(6);
        chk("raw", o_raw_status, 32'h0007_ffff);
        chk("irq", o_irq, 32'h0);
        chk("fast", o_fast_irq, 32'h0);
        $display("test disable done");
        // Only slot 5's channel requests, then slot 0's channel turns fast
        en = '1;
        fs = '0;
        sen = '1;
        fl = 53'h100_0000;
        wt(6);
        chk("live slot", o_vector_addr, 32'h0000_1014);
        fl = 53'h100_0004;
        fs = 32'h0000_0004;
        wt(6);
        chk("fast skips slot", o_vector_addr, 32'h0000_1014);
        chk("fast beside irq", {o_fast_irq, o_irq}, 32'h3);
        $display("test priority done");
        // Reset in mid-run clears every output at once
        i_rst_n = 1'b0;
        wt(1);
        chk("reset lines", {o_fast_irq, o_irq}, 32'h0);
        chk("reset vector", o_vector_addr, RST_ADDR);
        i_rst_n = 1'b1;
        wt(6);
        chk("after reset", o_vector_addr, 32'h0000_1014);
        $display("test reset done");
        close_out();
    end
endmodule : vectored_irq_ctrl_tb
